//--- src/prp_defines.svh
`ifndef PRP_DEFINES_SVH
`define PRP_DEFINES_SVH

// Register byte offsets
`define PRP_OFS_BUS_MODE      14'h0000
`define PRP_OFS_CYCLE_LO      14'h0004
`define PRP_OFS_CYCLE_HI      14'h0008
`define PRP_OFS_BUS_WIDTH     14'h000C
`define PRP_OFS_STATUS        14'h0010

// Bus mode control fields
`define PRP_BMC_CKM_LSB       0
`define PRP_BMC_CKM_MSB       1
`define PRP_BMC_SPEC_BIT      4

// Status fields
`define PRP_ST_STOP_ACK       0
`define PRP_ST_MEM_BUSY       1
`define PRP_ST_STRAP_DONE     2

// Bus width defaults per strap code
`define PRP_WIDTH_32          16'hAAAA
`define PRP_WIDTH_16          16'h5555
`define PRP_WIDTH_8           16'h0000
`define PRP_WIDTH_RSVD        16'h0000

// Reset values before straps are applied
`define PRP_RST_CKM           2'h0
`define PRP_RST_SPEC          1'h0
`define PRP_RST_WIDTH         16'h0000

`define PRP_ADDR_BITS         14

`endif

//--- src/prp_pkg.sv
package prp_pkg;

	typedef struct packed {
		logic        area_enable;
		logic [1:0]  clock_divide;
		logic [1:0]  bus_width;
		logic        bus_spec;
	} prp_strap_s;

	typedef enum logic [1:0] {
		PRP_W32,
		PRP_W16,
		PRP_W8,
		PRP_WRSVD
	} prp_width_e;

	typedef struct packed {
		logic [31:0] paddr;
		logic        pwrite;
		logic [31:0] pwdata;
	} prp_apb_req_s;

endpackage

//--- src/prp_top.sv
// Functional notes
// - Drive enable high while read data returned
// - Bus clocks derived from main input; second input level only gates the low-delay clock
// - Stop request answered with stop acknowledge
// - Area enables loaded from enable strap
// - Divide strap copied into divide bits
// - Divided clock serves system and bus outputs
// - Width strap selects bus width default
// - Spec strap copied into spec bit
// - Retry on mode write or busy write
// - Reset clears all registers asynchronously
`timescale 1ns/10ps
`include "prp_defines.svh"

module prp_top #(
	parameter int N_AREAS = 8
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire prp_pkg::prp_apb_req_s apb_req,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire prp_pkg::prp_strap_s straps,
	input  wire logic               mem_busy,
	input  wire logic               second_clock_in,
	input  wire logic               stop_request,
	output logic                    stop_ack,
	output logic                    retry_request,
	output logic                    read_data_drive,
	output logic                    bus_clock_out,
	output logic                    low_delay_bus_clock_out,
	output logic                    sys_clk_tick,
	output logic [N_AREAS-1:0]      area_enable_bits,
	output logic [1:0]              clock_divide_bits,
	output logic                    bus_spec_select,
	output logic [15:0]             bus_width_reg
);
	import prp_pkg::*;

	localparam int HALF = N_AREAS / 2;

	generate
		if (N_AREAS < 2 || N_AREAS > 32 || (N_AREAS % 2) != 0)
		begin : g_bad_areas
			$error("prp_top: N_AREAS must be even and 2..32");
		end
	endgenerate

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic logic [2:0] reg_sel(input logic [`PRP_ADDR_BITS-1:0] a);
		logic [`PRP_ADDR_BITS-1:0] ofs;
		ofs = {a[`PRP_ADDR_BITS-1:2], 2'h0};
		case (ofs)
			`PRP_OFS_BUS_MODE:  reg_sel = 3'h1;
			`PRP_OFS_CYCLE_LO:  reg_sel = 3'h2;
			`PRP_OFS_CYCLE_HI:  reg_sel = 3'h3;
			`PRP_OFS_BUS_WIDTH: reg_sel = 3'h4;
			`PRP_OFS_STATUS:    reg_sel = 3'h5;
			default:            reg_sel = 3'h0;
		endcase
	endfunction

	function automatic logic [15:0] width_default(input logic [1:0] code);
		case (prp_width_e'(code))
			PRP_W32: width_default = `PRP_WIDTH_32;
			PRP_W16: width_default = `PRP_WIDTH_16;
			PRP_W8:  width_default = `PRP_WIDTH_8;
			default: width_default = `PRP_WIDTH_RSVD;
		endcase
	endfunction

	function automatic logic [31:0] mode_word(input logic [1:0] ckm, input logic spec);
		mode_word = 32'h0000_0000;
		mode_word[`PRP_BMC_CKM_MSB:`PRP_BMC_CKM_LSB] = ckm;
		mode_word[`PRP_BMC_SPEC_BIT] = spec;
	endfunction

	function automatic logic [31:0] status_word(input logic ack, input logic busy,
		input logic done);
		status_word = 32'h0000_0000;
		status_word[`PRP_ST_STOP_ACK] = ack;
		status_word[`PRP_ST_MEM_BUSY] = busy;
		status_word[`PRP_ST_STRAP_DONE] = done;
	endfunction

	logic [2:0]  sel_now;
	logic        setup_phase;
	logic        access_done;
	logic        wr_done;
	logic        wr_refused;
	logic        blocked_reg;
	logic        strap_done_reg;
	logic [1:0]  div_cnt_reg;
	logic [1:0]  div_last;
	logic        second_seen_reg;

	// Address bits above the low 14 never reach the decode
	assign sel_now     = reg_sel(apb_req.paddr[`PRP_ADDR_BITS-1:0]);
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready;
	// Writes while memory is busy are dropped; the retry tells software to redo them
	assign wr_refused  = mem_busy;
	assign wr_done     = access_done && apb_req.pwrite && !blocked_reg && sel_now != 3'h0;
	assign div_last    = clock_divide_bits;

	// ------------------------------------------------------------
	// APB answer: fixed one-cycle access phase
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pready          <= 1'b0;
			pslverr         <= 1'b0;
			prdata          <= 32'h0000_0000;
			read_data_drive <= 1'b0;
		end
		else
		begin
			pready          <= setup_phase;
			pslverr         <= setup_phase && sel_now == 3'h0;
			read_data_drive <= setup_phase && !apb_req.pwrite && sel_now != 3'h0;
			prdata          <= 32'h0000_0000;
			if (setup_phase && !apb_req.pwrite)
			begin
				case (sel_now)
					3'h1: prdata <= mode_word(clock_divide_bits, bus_spec_select);
					3'h2: prdata <= 32'(area_enable_bits[HALF-1:0]);
					3'h3: prdata <= 32'(area_enable_bits[N_AREAS-1:HALF]);
					3'h4: prdata <= 32'(bus_width_reg);
					3'h5: prdata <= status_word(stop_ack, mem_busy, strap_done_reg);
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Retry
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			retry_request <= 1'b0;
		else
			retry_request <= setup_phase && apb_req.pwrite
				&& (sel_now == 3'h1 || (wr_refused && sel_now != 3'h0));
	end

	// Busy judged once, at setup, so busy drops and busy retries agree; mode writes also retry when not dropped
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			blocked_reg <= 1'b0;
		else
			blocked_reg <= setup_phase && wr_refused;
	end

	// ------------------------------------------------------------
	// Strap capture and configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			strap_done_reg <= 1'b0;
		else
			strap_done_reg <= 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			clock_divide_bits <= `PRP_RST_CKM;
			bus_spec_select   <= `PRP_RST_SPEC;
			bus_width_reg     <= `PRP_RST_WIDTH;
		end
		else if (!strap_done_reg)
		begin
			clock_divide_bits <= straps.clock_divide;
			bus_spec_select   <= straps.bus_spec;
			bus_width_reg     <= width_default(straps.bus_width);
		end
		else if (wr_done)
		begin
			if (sel_now == 3'h1)
			begin
				clock_divide_bits <= apb_req.pwdata[`PRP_BMC_CKM_MSB:`PRP_BMC_CKM_LSB];
				bus_spec_select   <= apb_req.pwdata[`PRP_BMC_SPEC_BIT];
			end
			if (sel_now == 3'h4)
				bus_width_reg <= apb_req.pwdata[15:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < N_AREAS; gi++)
		begin : g_area
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
					area_enable_bits[gi] <= 1'b0;
				else if (!strap_done_reg)
					area_enable_bits[gi] <= straps.area_enable;
				else if (wr_done && sel_now == ((gi < HALF) ? 3'h2 : 3'h3))
					area_enable_bits[gi] <= apb_req.pwdata[gi % HALF];
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Clock divider
	// ------------------------------------------------------------
	// Divided waveform is a registered copy of clk, so divide-by-1
	// cannot toggle and holds high; sys_clk_tick carries the rate.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			div_cnt_reg <= 2'h0;
		else if (div_cnt_reg >= div_last)
			div_cnt_reg <= 2'h0;
		else
			div_cnt_reg <= div_cnt_reg + 2'h1;
	end

	// Second input is only seen as a level; a tied-low input keeps
	// the low-delay output parked low.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			second_seen_reg <= 1'b0;
		else if (second_clock_in)
			second_seen_reg <= 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bus_clock_out           <= 1'b0;
			low_delay_bus_clock_out <= 1'b0;
			sys_clk_tick            <= 1'b0;
		end
		else
		begin
			bus_clock_out           <= {1'b0, div_cnt_reg, 1'b0} < {2'h0, div_last} + 4'h1;
			low_delay_bus_clock_out <= second_seen_reg
				&& ({1'b0, div_cnt_reg, 1'b0} < {2'h0, div_last} + 4'h1);
			sys_clk_tick            <= div_cnt_reg >= div_last;
		end
	end

	// ------------------------------------------------------------
	// Stop handshake
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stop_ack <= 1'b0;
		else
			stop_ack <= stop_request;
	end

endmodule

//--- dv/prp_cpu_model.sv
`timescale 1ns/10ps
module prp_cpu_model (
	input  wire logic clk,
	input  wire logic stop_cmd,
	input  wire logic busy_cmd,
	output logic      stop_request,
	output logic      mem_busy,
	output logic      second_clock_in
);
	initial
	begin
		stop_request = 1'b0;
		mem_busy = 1'b0;
		second_clock_in = 1'b0;
	end
	// Levels move just after an edge, like the core's own flops
	always @(posedge clk)
	begin
		stop_request <= stop_cmd;
		mem_busy <= busy_cmd;
		second_clock_in <= ~second_clock_in;
	end
endmodule

//--- dv/prp_top_sva.sv
`timescale 1ns/10ps
module prp_top_sva #(
	parameter int N_AREAS = 8
) (
	input wire logic         clk,
	input wire logic         rst,
	input wire logic         psel,
	input wire logic         penable,
	input wire prp_pkg::prp_apb_req_s apb_req,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire logic         retry_request,
	input wire logic         read_data_drive,
	input wire logic         mem_busy,
	input wire logic         stop_request,
	input wire logic         stop_ack
);
	import prp_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic mapped;
	assign mapped = apb_req.paddr[13:2] <= 12'h004;
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable && pready;
	endsequence
	ready_after_setup_a: assert property (setup_s |=> pready) else $error("late ready");
	ready_in_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
	read_drive_on_a: assert property (access_s ##0 (!apb_req.pwrite && mapped) |-> read_data_drive)
		else $error("no drive on read");
	read_drive_only_a: assert property (read_data_drive |-> pready && !apb_req.pwrite && !pslverr)
		else $error("drive outside read");
	mode_retry_a: assert property (access_s ##0 (apb_req.pwrite && apb_req.paddr[13:2] == 12'h000)
		|-> retry_request) else $error("no retry on mode write");
	busy_retry_a: assert property (setup_s ##0 (apb_req.pwrite && mem_busy && mapped) ##1 mem_busy
		|-> retry_request) else $error("no retry while busy");
	retry_cause_a: assert property (retry_request |-> pready && apb_req.pwrite)
		else $error("stray retry");
	unmapped_err_a: assert property (access_s ##0 !mapped |-> pslverr)
		else $error("no error on unmapped");
	stop_rise_a: assert property ($rose(stop_request) |=> stop_ack) else $error("no stop ack");
	stop_fall_a: assert property ($fell(stop_request) |=> !stop_ack) else $error("ack held");
endmodule
bind prp_top prp_top_sva #(.N_AREAS(N_AREAS)) u_sva (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .apb_req(apb_req), .pready(pready), .pslverr(pslverr),
	.retry_request(retry_request), .read_data_drive(read_data_drive), .mem_busy(mem_busy),
	.stop_request(stop_request), .stop_ack(stop_ack));

//--- dv/testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %0t: got %0h exp %0h", $time, g, e); end end
module testbench;
	import prp_pkg::*;
	logic         clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic         stop_cmd = 1'b0, busy_cmd = 1'b0, bus_spec_select, er, rt, dv;
	prp_apb_req_s req = '0;
	prp_strap_s   straps = '0;
	logic [31:0]  prdata, rd, seed = 32'hAE72FDCF;
	logic         pready, pslverr, stop_request, mem_busy, second_clock_in, stop_ack;
	logic         retry_request, read_data_drive, bus_clock_out, ld_clk, sys_clk_tick;
	logic [7:0]   area_enable_bits;
	logic [1:0]   clock_divide_bits;
	logic [15:0]  bus_width_reg;
	int           fails = 0, check_count = 0, cycles = 0, mode_m, width_m;
	prp_top #(.N_AREAS(8)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .straps(straps),
		.mem_busy(mem_busy), .second_clock_in(second_clock_in), .stop_request(stop_request),
		.stop_ack(stop_ack), .retry_request(retry_request), .read_data_drive(read_data_drive),
		.bus_clock_out(bus_clock_out), .low_delay_bus_clock_out(ld_clk),
		.sys_clk_tick(sys_clk_tick), .area_enable_bits(area_enable_bits),
		.clock_divide_bits(clock_divide_bits), .bus_spec_select(bus_spec_select),
		.bus_width_reg(bus_width_reg));
	prp_cpu_model cpu (.clk(clk), .stop_cmd(stop_cmd), .busy_cmd(busy_cmd),
		.stop_request(stop_request), .mem_busy(mem_busy), .second_clock_in(second_clock_in));
	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			fails++;
			report_and_stop();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task report_and_stop();
		$display("Counts: checks %0d errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Answer is sampled before that edge's updates land
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		req <= '{paddr: {seed[31:14], a}, pwrite: w, pwdata: d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		rt = retry_request;
		dv = read_data_drive;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic boot(input logic [1:0] code);
		int t = 0;
		int h = 0;
		int l = 0;
		rst <= 1'b1;
		straps <= '{area_enable: seed[0], clock_divide: code, bus_width: code,
			bus_spec: code == 2'h0 ? 1'b0 : seed[1]};
		seed = lfsr(seed);
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		mode_m = {27'h0, straps.bus_spec, 2'h0, code};
		width_m = code == 2'h0 ? 'hAAAA : code == 2'h1 ? 'h5555 : 0;
		`CHK(area_enable_bits, {8{straps.area_enable}})
		`CHK(clock_divide_bits, code)
		`CHK(bus_spec_select, straps.bus_spec)
		`CHK(bus_width_reg, width_m[15:0])
		apb(1'b0, 14'h0000, 32'h0);
		`CHK(rd, mode_m)
		`CHK(dv, 1'b1)
		`CHK(er, 1'b0)
		repeat (24)
		begin
			@(posedge clk);
			t += sys_clk_tick;
			h += bus_clock_out;
			l += ld_clk;
		end
		`CHK(t, 24 / (code + 1))
		`CHK(h, (code + 2) / 2 * 24 / (code + 1))
		`CHK(l, (code + 2) / 2 * 24 / (code + 1))
	endtask
	initial
	begin
		for (int c = 0; c < 4; c++)
		begin
			boot(c[1:0]);
			apb(1'b1, 14'h0000, seed);
			`CHK(rt, 1'b1)
			mode_m = {27'h0, seed[4], 2'h0, seed[1:0]};
			apb(1'b0, 14'h0000, 32'h0);
			`CHK(rd, mode_m)
			busy_cmd <= 1'b1;
			apb(1'b1, 14'h000C, seed);
			`CHK(rt, 1'b1)
			busy_cmd <= 1'b0;
			apb(1'b0, 14'h000C, 32'h0);
			`CHK(rd, width_m)
			seed = lfsr(seed);
			apb(1'b1, 14'h000C, seed);
			`CHK(rt, 1'b0)
			apb(1'b0, 14'h000C, 32'h0);
			`CHK(rd, {16'h0, seed[15:0]})
			apb(1'b1, 14'h0004, seed);
			apb(1'b1, 14'h0008, ~seed);
			apb(1'b0, 14'h0004, 32'h0);
			`CHK(rd, {28'h0, seed[3:0]})
			apb(1'b0, 14'h0008, 32'h0);
			`CHK(rd, {28'h0, ~seed[3:0]})
			`CHK(area_enable_bits, {~seed[3:0], seed[3:0]})
		end
		apb(1'b0, 14'h0014, 32'h0);
		`CHK(dv, 1'b0)
		`CHK(er, 1'b1)
		stop_cmd <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(stop_ack, 1'b1)
		apb(1'b0, 14'h0010, 32'h0);
		`CHK(rd[0], 1'b1)
		stop_cmd <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(stop_ack, 1'b0)
		report_and_stop();
	end
endmodule
